// ---- sdm_defs.vh ----
// Constants for the step and direction controller that drives the
// microstep driver board from outside. Assumes a 10 MHz hclk.
// Operation
// - Hold step high at least 2 us
// - Set direction stable before raising step
// - Change switches only with power off
// - External mode lines need sixteenth-step switches
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SDM_A_CTRL 8'h00
`define SDM_A_STEPS 8'h04
`define SDM_A_STAT 8'h08
`define SDM_A_POS 8'h0C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SDM_C_ENA 0
`define SDM_C_RSTN 1
`define SDM_C_DIR 2
`define SDM_C_MODE_LO 4
`define SDM_C_MODE_HI 6
`define SDM_C_TQ 8
// Eighth step code, torque high, enabled, reset released
`define SDM_CTRL_RST 32'h0000_0153
`define SDM_MODE_W 3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SDM_S_BUSY 0
`define SDM_S_FAULT 1
`define SDM_S_STBY 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SDM_CLK_MHZ 10
`define SDM_STEP_HI_NS 2000
`define SDM_SETUP_NS 200
// Least times round up to whole cycles
`define SDM_STEP_HI_CYC ((`SDM_STEP_HI_NS*`SDM_CLK_MHZ+999)/1000)
`define SDM_SETUP_CYC ((`SDM_SETUP_NS*`SDM_CLK_MHZ+999)/1000)

`endif

// ---- sdm_pulse_gen.v ----
// Step pulse timer: on start waits setup, holds step high
// for the least high time, then low for the same. Assumes hclk.
`timescale 1ns/1ns
`include "sdm_defs.vh"

module sdm_pulse_gen #(
  parameter CW = 8,
  parameter SETUP_CYC = `SDM_SETUP_CYC,
  parameter HIGH_CYC = `SDM_STEP_HI_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire start,
  output reg step_out_r,
  output reg busy_r,
  output reg done_r
);

  localparam S_IDLE = 2'd0;
  localparam S_SETUP = 2'd1;
  localparam S_HIGH = 2'd2;
  localparam S_LOW = 2'd3;

  reg [1:0] st_r;
  reg [CW-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
      cnt_r <= {CW{1'b0}};
      step_out_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (start) begin
            st_r <= S_SETUP;
            busy_r <= 1'b1;
            cnt_r <= SETUP_CYC[CW-1:0] - 1'b1;
          end
        end
        S_SETUP: begin
          if (cnt_r == {CW{1'b0}}) begin
            st_r <= S_HIGH;
            step_out_r <= 1'b1;
            cnt_r <= HIGH_CYC[CW-1:0] - 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_HIGH: begin
          if (cnt_r == {CW{1'b0}}) begin
            st_r <= S_LOW;
            step_out_r <= 1'b0;
            cnt_r <= HIGH_CYC[CW-1:0] - 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          if (cnt_r == {CW{1'b0}}) begin
            st_r <= S_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

endmodule // sdm_pulse_gen

// ---- sdm_ctrl.v ----
// Host-side step and direction controller with an AHB-Lite slave.
// Drives the driver board pins; assumes inputs synchronous to hclk.
`timescale 1ns/1ns
`include "sdm_defs.vh"

module sdm_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg step_out,
  output reg dir_out,
  output reg enable_out,
  output reg sequencer_reset_n,
  output reg step_res_sel_bit0,
  output reg step_res_sel_bit1,
  output reg step_res_sel_bit2,
  output reg torque_scale_select,
  input wire thermal_fault
);

  reg [31:0] ctrl_r;
  reg [15:0] steps_r;
  reg [31:0] pos_r;
  reg dir_lat_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg start_r;
  wire pg_step;
  wire pg_busy;
  wire pg_done;
  wire [2:0] mode;
  wire stby;
  wire active;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mode code to position increment in sixteenths per step; zero means standby
  function [4:0] sdm_incr;
    input [2:0] m;
    begin
      case (m)
        3'h1: sdm_incr = 5'h10; // full
        3'h2: sdm_incr = 5'h08; // half A
        3'h3: sdm_incr = 5'h08; // half B
        3'h4: sdm_incr = 5'h04; // quarter
        3'h5: sdm_incr = 5'h02; // eighth
        3'h6: sdm_incr = 5'h01; // sixteenth
        default: sdm_incr = 5'h00;
      endcase
    end
  endfunction

  assign mode = ctrl_r[`SDM_C_MODE_HI:`SDM_C_MODE_LO];
  assign stby = (sdm_incr(mode) == 5'h00);
  assign active = ctrl_r[`SDM_C_ENA] & ctrl_r[`SDM_C_RSTN] & ~stby &
                  ~thermal_fault;

  // ----------------------------------------------------------------
  // Step pulse timing
  // ----------------------------------------------------------------
  sdm_pulse_gen #(
    .CW(8),
    .SETUP_CYC(`SDM_SETUP_CYC),
    .HIGH_CYC(`SDM_STEP_HI_CYC)
  ) u_pg (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start_r),
    .step_out_r(pg_step),
    .busy_r(pg_busy),
    .done_r(pg_done)
  );

  // ----------------------------------------------------------------
  // Bus slave: zero wait states, writes land in the data phase
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_r <= hwrite;
        wr_addr_r <= haddr;
        if (!hwrite) begin
          if (haddr == `SDM_A_CTRL) begin
            hrdata <= ctrl_r;
          end else if (haddr == `SDM_A_STEPS) begin
            hrdata <= {16'h0000, steps_r};
          end else if (haddr == `SDM_A_STAT) begin
            hrdata <= {29'h0000_0000, stby, thermal_fault,
                       pg_busy | (steps_r != 16'h0000)};
          end else if (haddr == `SDM_A_POS) begin
            hrdata <= pos_r;
          end else begin
            hrdata <= 32'h0000_0000;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and step scheduling
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `SDM_CTRL_RST;
      steps_r <= 16'h0000;
      pos_r <= 32'h0000_0000;
      dir_lat_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_pend_r && wr_addr_r == `SDM_A_CTRL) begin
        ctrl_r <= hwdata & 32'h0000_0177;
      end else if (wr_pend_r && wr_addr_r == `SDM_A_POS) begin
        pos_r <= hwdata;
      end
      if (wr_pend_r && wr_addr_r == `SDM_A_STEPS) begin
        steps_r <= hwdata[15:0];
      end else if (!active) begin
        steps_r <= 16'h0000;
      end else if (!pg_busy && !start_r && steps_r != 16'h0000) begin
        start_r <= 1'b1;
        dir_lat_r <= ctrl_r[`SDM_C_DIR];
        steps_r <= steps_r - 16'h0001;
      end
      if (!ctrl_r[`SDM_C_RSTN]) begin
        pos_r <= 32'h0000_0000;
      end else if (pg_done) begin
        if (dir_lat_r) begin
          pos_r <= pos_r + {27'h0000000, sdm_incr(mode)};
        end else begin
          pos_r <= pos_r - {27'h0000000, sdm_incr(mode)};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive; switch ON equals a low level
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_out <= 1'b0;
      dir_out <= 1'b0;
      enable_out <= 1'b0;
      sequencer_reset_n <= 1'b0;
      step_res_sel_bit0 <= 1'b1;
      step_res_sel_bit1 <= 1'b0;
      step_res_sel_bit2 <= 1'b1;
      torque_scale_select <= 1'b1;
    end else begin
      step_out <= pg_step;
      dir_out <= dir_lat_r;
      enable_out <= ctrl_r[`SDM_C_ENA];
      sequencer_reset_n <= ctrl_r[`SDM_C_RSTN];
      step_res_sel_bit0 <= mode[0];
      step_res_sel_bit1 <= mode[1];
      step_res_sel_bit2 <= mode[2];
      torque_scale_select <= ctrl_r[`SDM_C_TQ];
    end
  end

endmodule // sdm_ctrl

// ---- sdm_board_model.sv ----
// Driver board model: counts microstep position from step pins.
// Assumes pins come straight from the controller under test.
`timescale 1ns/1ns
module sdm_board_model (
  input wire step,
  input wire dir,
  input wire ena,
  input wire rst_n,
  input wire [2:0] sel,
  input wire hot,
  output wire fault,
  output reg [31:0] pos
);
  wire stby = (sel == 3'h0) || (sel == 3'h7);
  // Increment in sixteenths; both half step codes move eight
  wire [31:0] inc = (sel == 3'h1) ? 32'h10 : (sel < 3'h4) ? 32'h8 :
    32'h1 << (3'h6 - sel);
  assign fault = hot;
  always @(posedge step or negedge rst_n) begin
    if (!rst_n)
      pos <= 32'h0;
    else if (ena && !stby && !hot)
      pos <= dir ? pos + inc : pos - inc;
  end
endmodule // sdm_board_model

// ---- sdm_ctrl_chk_monitor.sv ----
// Checker for step pulse timing of sdm_ctrl.
// Bound to every sdm_ctrl instance.
`timescale 1ns/1ns
module sdm_ctrl_chk (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire step_out,
  input wire dir_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg [7:0] hi_c;
  reg [7:0] lo_c;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_c <= 8'h0;
      lo_c <= 8'hFF;
    end else begin
      hi_c <= step_out ? hi_c + 8'h1 : 8'h0;
      lo_c <= step_out ? 8'h0 : (lo_c == 8'hFF ? lo_c : lo_c + 8'h1);
    end
  end
  property p_hi; $fell(step_out) |-> hi_c >= 8'h14; endproperty
  a_hi: assert property (p_hi) else $error("step high too short");
  property p_lo; $rose(step_out) |-> lo_c >= 8'h14; endproperty
  a_lo: assert property (p_lo) else $error("step low too short");
  property p_dir; $rose(step_out) |-> $stable(dir_out); endproperty
  a_dir: assert property (p_dir) else $error("dir moved at step");
  property p_dh; step_out && $past(step_out) |-> $stable(dir_out);
  endproperty
  a_dh: assert property (p_dh) else $error("dir moved in pulse");
  property p_ok; hreadyout && hresp == 1'b0; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready or error");
endmodule // sdm_ctrl_chk
bind sdm_ctrl sdm_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .step_out(step_out),
  .dir_out(dir_out));

// ---- tb.sv ----
// Bench for sdm_ctrl: AHB-Lite register tests against a board model.
// Assumes a 10 MHz hclk and the register map of sdm_defs.vh.
`timescale 1ns/1ns
`include "sdm_defs.vh"
module tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg [7:0] haddr = 8'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg hot = 1'b0;
  wire [31:0] hrdata;
  wire [31:0] mpos;
  wire hready, hresp, step, dir, ena, rst_n, s0, s1, s2, tq, fault;
  integer miscompares = 0;
  integer tests_run = 0;
  integer m;
  integer e;
  reg [31:0] q;
  reg [31:0] r;
  reg [31:0] p0;
  sdm_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .step_out(step), .dir_out(dir),
    .enable_out(ena), .sequencer_reset_n(rst_n), .step_res_sel_bit0(s0),
    .step_res_sel_bit1(s1), .step_res_sel_bit2(s2),
    .torque_scale_select(tq), .thermal_fault(fault));
  sdm_board_model bm (.step(step), .dir(dir), .ena(ena), .rst_n(rst_n),
    .sel({s2, s1, s0}), .hot(hot), .fault(fault), .pos(mpos));
  initial forever #50 hclk = ~hclk;
  task give_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0s exp %h got %h", nm, exp, got);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task rd(input [7:0] a, input [31:0] x, input [63:0] nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  task run(input [31:0] n);
    xfer(1'b1, `SDM_A_STEPS, n);
    r = 32'h1;
    for (e = 0; e < 400 && (r !== 32'h0 || q[0] !== 1'b0); e = e + 1) begin
      xfer(1'b0, `SDM_A_STEPS, 32'h0);
      r = q;
      xfer(1'b0, `SDM_A_STAT, 32'h0);
    end
    if (e >= 400) begin
      miscompares = miscompares + 1;
      $display("[FAIL] run exp idle got busy");
    end
  endtask
  function [31:0] ctl(input [2:0] md, input d, input t);
    ctl = {23'h0, t, 1'b0, md, 1'b0, d, 2'h3};
  endfunction
  initial begin
    #3000000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge hclk);
    chk("sel", {29'h0, s2, s1, s0}, 32'h5);
    chk("torque", {31'h0, tq}, 32'h1);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`SDM_A_CTRL, `SDM_CTRL_RST, "ctrl");
    rd(8'h10, 32'h0, "unmap");
    $display("defaults done");
    for (m = 1; m < 7; m = m + 1) begin
      xfer(1'b1, `SDM_A_CTRL, ctl(m[2:0], 1'b1, m[0]));
      xfer(1'b1, `SDM_A_POS, 32'h0);
      p0 = mpos;
      run(32'h2);
      e = (m == 1) ? 16 : (m < 4) ? 8 : 1 << (6 - m);
      chk("torque", {31'h0, tq}, {31'h0, m[0]});
      chk("mode", {29'h0, s2, s1, s0}, m);
      chk("model", mpos - p0, 2 * e);
      rd(`SDM_A_POS, 2 * e, "pos");
    end
    $display("modes done");
    xfer(1'b1, `SDM_A_CTRL, ctl(3'h6, 1'b0, 1'b1));
    xfer(1'b1, `SDM_A_POS, 32'h5);
    p0 = mpos;
    run(32'h1);
    chk("down", mpos, p0 - 32'h1);
    rd(`SDM_A_POS, 32'h4, "pos");
    $display("direction done");
    for (m = 0; m < 8; m = m + 7) begin
      xfer(1'b1, `SDM_A_CTRL, ctl(m[2:0], 1'b1, 1'b1));
      p0 = mpos;
      xfer(1'b1, `SDM_A_STEPS, 32'h3);
      // Count clears one cycle after the write lands
      @(posedge hclk);
      rd(`SDM_A_STEPS, 32'h0, "steps");
      rd(`SDM_A_STAT, 32'h4, "stat");
      chk("model", mpos, p0);
    end
    $display("standby done");
    xfer(1'b1, `SDM_A_CTRL, `SDM_CTRL_RST);
    hot <= 1'b1;
    rd(`SDM_A_STAT, 32'h2, "stat");
    xfer(1'b1, `SDM_A_STEPS, 32'h1);
    @(posedge hclk);
    rd(`SDM_A_STEPS, 32'h0, "steps");
    hot <= 1'b0;
    rd(`SDM_A_STAT, 32'h0, "stat");
    $display("thermal done");
    xfer(1'b1, `SDM_A_CTRL, 32'h0000_0152);
    xfer(1'b1, `SDM_A_STEPS, 32'h1);
    @(posedge hclk);
    rd(`SDM_A_STEPS, 32'h0, "steps");
    chk("ena", {31'h0, ena}, 32'h0);
    $display("enable done");
    xfer(1'b1, `SDM_A_POS, 32'h9);
    xfer(1'b1, `SDM_A_CTRL, 32'h0000_0151);
    @(posedge hclk);
    rd(`SDM_A_POS, 32'h0, "pos");
    chk("model", mpos, 32'h0);
    $display("seq reset done");
    give_verdict;
  end
endmodule // tb
